/* File: rtl/bpc_top.sv */
// board power control: request arbitration, sleep states, front panel
// Notes on behaviour
// [RULE1] each power button press toggles system power
// [RULE2] watchdog expiry powers off or cycles per configured action
// [RULE3] chassis commands request power on, off or cycle
// [RULE4] power retention turns power on when AC returns
// [RULE5] chipset sleep signal drives system into or out of soft-off
// [RULE6] in working state fans follow sensor speed, buttons work
// [RULE7] front panel power LED is never driven here
// [RULE8] fans stopped in soft-off
// [RULE9] power, reset, diag, identify buttons unlocked in soft-off
// [RULE10] leaving soft-off always runs the full boot sequence
// [RULE11] only S0 and S5; S3 on workstation only; others rejected
// [RULE12] identify LED lit by button press or command
// [RULE13] system status LED driven, all button presses monitored
// [RULE14] secure lockout disables selected front panel buttons
// [RULE15] power-good loss while on is a power fault
// [RULE16] fault conditions emit beep code patterns
// [RULE17] off beats cycle, cycle beats on, in the same cycle
`timescale 1ns/100ps
module bpc_top #(
	parameter int BOOT_CYC = bpc_pkg::BPC_BOOT_CYC,
	parameter int CYCLE_CYC = bpc_pkg::BPC_CYCLE_CYC,
	parameter int BEEP_CYC = bpc_pkg::BPC_BEEP_CYC,
	parameter bit WORKSTATION = 1'b0
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// front panel buttons, one-cycle press pulses, and level lockout mask
	input wire logic pwr_btn_i,
	input wire logic rst_btn_i,
	input wire logic diag_btn_i,
	input wire logic ident_btn_i,
	input wire logic [3:0] lockout_i,
	// internal power sources, one-cycle pulses; watchdog action and retention enable are levels
	input wire logic wdt_expire_i,
	input wire logic wdt_action_i,
	input wire logic cmd_on_i,
	input wire logic cmd_off_i,
	input wire logic cmd_cycle_i,
	input wire logic cmd_ident_on_i,
	input wire logic cmd_ident_off_i,
	input wire logic ac_restored_i,
	input wire logic retain_en_i,
	input wire logic wol_i,
	// chipset side
	input wire logic [2:0] chipset_hub_slp_i,
	input wire logic chipset_hub_slp_vld_i,
	input wire logic pwr_good_i,
	// sensor fan demand
	input wire logic [7:0] fan_demand_i,
	// outputs
	output logic pwr_en_o,
	output logic sys_rst_o,
	output logic diag_int_o,
	output logic [7:0] fan_pwm_o,
	output logic chassis_identify_led_o,
	output logic status_led_o,
	output logic beep_o,
	output logic sleep_reject_o,
	output logic [3:0] btn_seen_o,
	output logic [2:0] acpi_state_o
);
	bpc_pkg::bpc_state_t state_r, state_nxt;
	logic [31:0] cnt_r;
	logic [3:0] lk;
	logic pwr_btn_ok, rst_btn_ok, diag_btn_ok, ident_btn_ok;
	logic req_on, req_off, req_cycle;
	logic slp_ok, slp_s5, slp_s0;
	logic fault_ev, beep_busy, beep_start;
	logic [3:0] beep_cnt;
	logic fault_r;

	// [RULE9] soft-off lifts lockout
	assign lk = (state_r == bpc_pkg::BPC_OFF) ? 4'h0 : lockout_i;
	// [RULE14] lockout masks buttons
	assign pwr_btn_ok = pwr_btn_i && !lk[bpc_pkg::BPC_LK_PWR];
	assign rst_btn_ok = rst_btn_i && !lk[bpc_pkg::BPC_LK_RST];
	assign diag_btn_ok = diag_btn_i && !lk[bpc_pkg::BPC_LK_DIAG];
	assign ident_btn_ok = ident_btn_i && !lk[bpc_pkg::BPC_LK_IDENT];

	// [RULE11] legal sleep requests only
	assign slp_s0 = chipset_hub_slp_i == bpc_pkg::BPC_SLP_S0;
	assign slp_s5 = chipset_hub_slp_i == bpc_pkg::BPC_SLP_S5;
	assign slp_ok = slp_s0 || slp_s5 ||
		(WORKSTATION && chipset_hub_slp_i == bpc_pkg::BPC_SLP_S3);

	// [RULE1] button toggles power
	// [RULE5] chipset sleep enters or leaves soft-off
	always_comb begin
		req_on = 1'b0;
		req_off = 1'b0;
		req_cycle = 1'b0;
		if (state_r == bpc_pkg::BPC_OFF) begin
			// [RULE4] AC return powers on
			req_on = pwr_btn_ok || cmd_on_i || wol_i ||
				(ac_restored_i && retain_en_i) ||
				(chipset_hub_slp_vld_i && slp_s0);
			req_cycle = cmd_cycle_i;
			req_off = cmd_off_i;
		end else begin
			req_off = pwr_btn_ok || cmd_off_i ||
				(wdt_expire_i && wdt_action_i == bpc_pkg::BPC_WDT_OFF) ||
				(chipset_hub_slp_vld_i && slp_s5);
			// [RULE2] watchdog cycle action
			req_cycle = cmd_cycle_i ||
				(wdt_expire_i && wdt_action_i == bpc_pkg::BPC_WDT_CYCLE);
			// [RULE3] chassis on while powered is a no-op
			req_on = cmd_on_i;
		end
	end
	// [RULE15] power-good lost while running
	assign fault_ev = (state_r == bpc_pkg::BPC_ON) && !pwr_good_i;

	// [RULE17] off, then cycle, then on
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			bpc_pkg::BPC_OFF: begin
				if (req_off)
					state_nxt = bpc_pkg::BPC_OFF;
				else if (req_cycle || req_on)
					// [RULE10] always full boot
					state_nxt = bpc_pkg::BPC_BOOT;
			end
			bpc_pkg::BPC_BOOT: begin
				if (req_off)
					state_nxt = bpc_pkg::BPC_SHUT;
				else if (req_cycle)
					state_nxt = bpc_pkg::BPC_CYCLE;
				else if (cnt_r == 32'h0 && pwr_good_i)
					state_nxt = bpc_pkg::BPC_ON;
				else if (cnt_r == 32'h0)
					state_nxt = bpc_pkg::BPC_FAULT;
			end
			bpc_pkg::BPC_ON: begin
				if (req_off)
					state_nxt = bpc_pkg::BPC_SHUT;
				else if (req_cycle)
					state_nxt = bpc_pkg::BPC_CYCLE;
				else if (fault_ev)
					state_nxt = bpc_pkg::BPC_FAULT;
			end
			bpc_pkg::BPC_SHUT:
				state_nxt = bpc_pkg::BPC_OFF;
			bpc_pkg::BPC_CYCLE: begin
				if (req_off)
					state_nxt = bpc_pkg::BPC_OFF;
				else if (cnt_r == 32'h0)
					state_nxt = bpc_pkg::BPC_BOOT;
			end
			bpc_pkg::BPC_FAULT:
				state_nxt = bpc_pkg::BPC_OFF;
			default:
				state_nxt = bpc_pkg::BPC_OFF;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			state_r <= bpc_pkg::BPC_OFF;
		else
			state_r <= state_nxt;
	end

	// boot and off-time counter, loaded on entry
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			cnt_r <= 32'h0;
		else if (state_nxt != state_r &&
				state_nxt == bpc_pkg::BPC_BOOT)
			cnt_r <= 32'(BOOT_CYC - 1);
		else if (state_nxt != state_r &&
				state_nxt == bpc_pkg::BPC_CYCLE)
			cnt_r <= 32'(CYCLE_CYC - 1);
		else if (cnt_r != 32'h0)
			cnt_r <= cnt_r - 32'h1;
	end

	// rail enable held through boot and run; reset held during boot
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_en_o <= 1'b0;
			sys_rst_o <= 1'b1;
		end else begin
			pwr_en_o <= state_nxt == bpc_pkg::BPC_BOOT ||
				state_nxt == bpc_pkg::BPC_ON;
			sys_rst_o <= state_nxt != bpc_pkg::BPC_ON ||
				(rst_btn_ok && state_r == bpc_pkg::BPC_ON);
		end
	end

	// [RULE6] fans follow sensors when on
	// [RULE8] fans stopped in soft-off
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			fan_pwm_o <= 8'h00;
		else if (state_r == bpc_pkg::BPC_ON ||
				state_r == bpc_pkg::BPC_BOOT)
			fan_pwm_o <= fan_demand_i;
		else
			fan_pwm_o <= 8'h00;
	end

	// [RULE12] identify by button or command
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			chassis_identify_led_o <= 1'b0;
		else if (ident_btn_ok)
			chassis_identify_led_o <= ~chassis_identify_led_o;
		else if (cmd_ident_on_i)
			chassis_identify_led_o <= 1'b1;
		else if (cmd_ident_off_i)
			chassis_identify_led_o <= 1'b0;
	end

	// sticky fault; cleared only by next successful power-on
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			fault_r <= 1'b0;
		else if (state_nxt == bpc_pkg::BPC_FAULT)
			fault_r <= 1'b1;
		else if (state_nxt == bpc_pkg::BPC_ON)
			fault_r <= 1'b0;
	end

	// [RULE13] status LED and press monitor
	// [RULE7] no power LED output by design
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_led_o <= 1'b0;
			btn_seen_o <= 4'h0;
			diag_int_o <= 1'b0;
			sleep_reject_o <= 1'b0;
		end else begin
			status_led_o <= !fault_r && state_r == bpc_pkg::BPC_ON;
			btn_seen_o <= {ident_btn_i, diag_btn_i, rst_btn_i, pwr_btn_i};
			diag_int_o <= diag_btn_ok && state_r == bpc_pkg::BPC_ON;
			// [RULE11] reject unsupported sleep
			sleep_reject_o <= chipset_hub_slp_vld_i && !slp_ok;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			acpi_state_o <= bpc_pkg::BPC_SLP_S5;
		else if (state_r == bpc_pkg::BPC_ON)
			acpi_state_o <= bpc_pkg::BPC_SLP_S0;
		else
			acpi_state_o <= bpc_pkg::BPC_SLP_S5;
	end

	// [RULE16] beep on fault or rejected sleep
	assign beep_start = !beep_busy &&
		(state_nxt == bpc_pkg::BPC_FAULT && state_r != state_nxt ||
		chipset_hub_slp_vld_i && !slp_ok);
	assign beep_cnt = (state_nxt == bpc_pkg::BPC_FAULT) ?
		4'(bpc_pkg::BPC_BEEPS_FAULT) : 4'(bpc_pkg::BPC_BEEPS_SLEEP);

	bpc_beeper #(
		.BEEP_CYC(BEEP_CYC)
	) u_beeper (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(beep_start),
		.count_i(beep_cnt),
		.busy_o(beep_busy),
		.beep_o(beep_o)
	);

	property p_btn_toggle_on; // [RULE1]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_OFF && pwr_btn_i && !cmd_off_i
		|=> state_r == bpc_pkg::BPC_BOOT;
	endproperty
	a_btn_toggle_on: assert property (p_btn_toggle_on) // [RULE1]
		else $error("power press in off did not boot");

	property p_wdt; // [RULE2]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_ON && wdt_expire_i && !pwr_btn_i &&
		!cmd_off_i && !chipset_hub_slp_vld_i
		|=> state_r == ($past(wdt_action_i) ? bpc_pkg::BPC_CYCLE :
			bpc_pkg::BPC_SHUT);
	endproperty
	a_wdt: assert property (p_wdt) // [RULE2]
		else $error("watchdog action not taken");

	property p_fans_off; // [RULE8]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_OFF ##1 state_r == bpc_pkg::BPC_OFF
		|-> fan_pwm_o == 8'h00;
	endproperty
	a_fans_off: assert property (p_fans_off) // [RULE8]
		else $error("fans running in soft off");

	sequence s_boot_enter;
		state_r == bpc_pkg::BPC_OFF ##1 state_r == bpc_pkg::BPC_BOOT;
	endsequence
	property p_full_boot; // [RULE10]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_OFF && state_nxt != bpc_pkg::BPC_OFF
		|-> s_boot_enter ##0 pwr_en_o && sys_rst_o;
	endproperty
	a_full_boot: assert property (p_full_boot) // [RULE10]
		else $error("soft off left without boot");

	property p_pg_fault; // [RULE15]
		@(posedge ref_clk_i) disable iff (rst_i)
		fault_ev && !req_off && !req_cycle
		|=> state_r == bpc_pkg::BPC_FAULT ##1 state_r == bpc_pkg::BPC_OFF;
	endproperty
	a_pg_fault: assert property (p_pg_fault) // [RULE15]
		else $error("power good loss not handled");

	property p_beep; // [RULE16]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_FAULT && !$past(beep_busy) |-> beep_busy;
	endproperty
	a_beep: assert property (p_beep) // [RULE16]
		else $error("fault without beep code");

	property p_prio; // [RULE17]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_ON && cmd_off_i && cmd_cycle_i
		|=> state_r == bpc_pkg::BPC_SHUT;
	endproperty
	a_prio: assert property (p_prio) // [RULE17]
		else $error("off did not beat cycle");

	property p_lockout; // [RULE14]
		@(posedge ref_clk_i) disable iff (rst_i)
		state_r == bpc_pkg::BPC_ON && lockout_i[bpc_pkg::BPC_LK_IDENT] &&
		ident_btn_i && !cmd_ident_on_i && !cmd_ident_off_i
		|=> $stable(chassis_identify_led_o);
	endproperty
	a_lockout: assert property (p_lockout) // [RULE14]
		else $error("locked identify button acted");
endmodule

/* File: rtl/bpc_pkg.sv */
// constants shared by the board power control block
package bpc_pkg;
	// power sequencer states, one-hot
	typedef enum logic [5:0] {
		BPC_OFF = 6'h01,
		BPC_BOOT = 6'h02,
		BPC_ON = 6'h04,
		BPC_SHUT = 6'h08,
		BPC_CYCLE = 6'h10,
		BPC_FAULT = 6'h20
	} bpc_state_t;

	// requested sleep state codes from the chipset
	localparam logic [2:0] BPC_SLP_S0 = 3'h0;
	localparam logic [2:0] BPC_SLP_S3 = 3'h3;
	localparam logic [2:0] BPC_SLP_S5 = 3'h5;

	// watchdog action codes
	localparam logic BPC_WDT_OFF = 1'h0;
	localparam logic BPC_WDT_CYCLE = 1'h1;

	// lockout mask bit positions
	localparam int BPC_LK_PWR = 0;
	localparam int BPC_LK_RST = 1;
	localparam int BPC_LK_DIAG = 2;
	localparam int BPC_LK_IDENT = 3;

	// timing in microseconds, clock at 50 MHz
	localparam int BPC_CLK_MHZ = 50;
	localparam int BPC_BOOT_US = 100;
	localparam int BPC_CYCLE_US = 200;
	localparam int BPC_BEEP_US = 40;
	localparam int BPC_BOOT_CYC = BPC_BOOT_US * BPC_CLK_MHZ;
	localparam int BPC_CYCLE_CYC = BPC_CYCLE_US * BPC_CLK_MHZ;
	localparam int BPC_BEEP_CYC = BPC_BEEP_US * BPC_CLK_MHZ;
	localparam int BPC_BEEPS_FAULT = 3;
	localparam int BPC_BEEPS_SLEEP = 1;
endpackage

/* File: rtl/bpc_beeper.sv */
// diagnostic beep code generator
`timescale 1ns/100ps
module bpc_beeper #(
	parameter int BEEP_CYC = bpc_pkg::BPC_BEEP_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// request
	input wire logic start_i,
	input wire logic [3:0] count_i,
	// output
	output logic busy_o,
	output logic beep_o
);
	logic [31:0] tick_r;
	logic [4:0] phase_r;

	assign busy_o = (phase_r != 5'h00);

	// each beep is one on slot then one off slot
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_r <= 32'h0;
			phase_r <= 5'h00;
		end else if (!busy_o) begin
			if (start_i && count_i != 4'h0) begin
				phase_r <= {count_i, 1'b0};
				tick_r <= 32'(BEEP_CYC - 1);
			end
		end else if (tick_r == 32'h0) begin
			phase_r <= phase_r - 5'h01;
			tick_r <= 32'(BEEP_CYC - 1);
		end else begin
			tick_r <= tick_r - 32'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			beep_o <= 1'b0;
		else
			beep_o <= busy_o && phase_r[0] == 1'b0 && !(tick_r == 32'h0);
	end
endmodule

/* File: tb/bpc_host_model.sv */
// host chipset stand-in: power-good follows the rail enable
`timescale 1ns/100ps
module bpc_host_model #(
	parameter int PG_DLY = 3
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// rail enable and fault injection
	input wire logic pwr_en_i,
	input wire logic drop_i,
	// power-good back to the controller
	output logic pwr_good_o
);
	int cnt_r;

	// good is gone one clock after the rail or the bench lets go
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 0;
		end else if (!pwr_en_i || drop_i) begin
			cnt_r <= 0;
		end else if (cnt_r < PG_DLY) begin
			cnt_r <= cnt_r + 1;
		end
	end

	assign pwr_good_o = (cnt_r == PG_DLY);
endmodule

/* File: tb/bpc_top_tb.sv */
// self-checking bench for board power control
`timescale 1ns/100ps
module bpc_top_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pwr_btn_i = 1'b0, rst_btn_i = 1'b0, diag_btn_i = 1'b0;
	logic ident_btn_i = 1'b0;
	logic [3:0] lockout_i = 4'h0;
	logic wdt_expire_i = 1'b0, wdt_action_i = 1'b0, cmd_on_i = 1'b0;
	logic cmd_off_i = 1'b0, cmd_cycle_i = 1'b0, cmd_ident_on_i = 1'b0;
	logic cmd_ident_off_i = 1'b0, ac_restored_i = 1'b0;
	logic retain_en_i = 1'b0, wol_i = 1'b0, drop = 1'b0;
	logic [2:0] chipset_hub_slp_i = 3'h0;
	logic chipset_hub_slp_vld_i = 1'b0;
	logic pwr_good_i;
	logic [7:0] fan_demand_i = 8'h5A;
	logic pwr_en_o, sys_rst_o, diag_int_o, chassis_identify_led_o;
	logic status_led_o, beep_o, sleep_reject_o;
	logic [7:0] fan_pwm_o;
	logic [3:0] btn_seen_o;
	logic [2:0] acpi_state_o;
	int miscompares = 0;
	int checks_done = 0;

	bpc_top #(.BOOT_CYC(8), .CYCLE_CYC(10), .BEEP_CYC(4),
		.WORKSTATION(1'b0)) u_dut (
		.ref_clk_i, .rst_i, .pwr_btn_i, .rst_btn_i, .diag_btn_i,
		.ident_btn_i, .lockout_i, .wdt_expire_i, .wdt_action_i, .cmd_on_i,
		.cmd_off_i, .cmd_cycle_i, .cmd_ident_on_i, .cmd_ident_off_i,
		.ac_restored_i, .retain_en_i, .wol_i, .chipset_hub_slp_i,
		.chipset_hub_slp_vld_i, .pwr_good_i, .fan_demand_i, .pwr_en_o,
		.sys_rst_o, .diag_int_o, .fan_pwm_o, .chassis_identify_led_o,
		.status_led_o, .beep_o, .sleep_reject_o, .btn_seen_o,
		.acpi_state_o);

	bpc_host_model #(.PG_DLY(3)) u_host (.ref_clk_i, .rst_i,
		.pwr_en_i(pwr_en_o), .drop_i(drop), .pwr_good_o(pwr_good_i));

	always #10 ref_clk_i = ~ref_clk_i;

	task automatic finish_test;
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: %h vs %h", $time, s, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	task automatic wait_led(input logic v);
		int i;
		for (i = 0; i < 60 && status_led_o !== v; i++)
			tick(1);
		chk(status_led_o, v);
	endtask

	// rising edges of the beeper over a fixed span
	task automatic beeps(input int n);
		int k;
		logic p;
		k = 0;
		p = 1'b0;
		repeat (80) begin
			tick(1);
			if (beep_o === 1'b1 && p !== 1'b1)
				k++;
			p = beep_o;
		end
		chk(8'(k), 8'(n));
	endtask

	// shutdown state lasts a cycle, so let it pass first
	task automatic turn_on;
		tick(3);
		pulse(cmd_on_i);
		wait_led(1'b1);
	endtask

	task automatic t_button;
		pulse(pwr_btn_i);
		chk(pwr_en_o, 1'b1);
		chk(sys_rst_o, 1'b1);
		wait_led(1'b1);
		tick(2);
		chk(sys_rst_o, 1'b0);
		chk(acpi_state_o, bpc_pkg::BPC_SLP_S0);
		chk(fan_pwm_o, fan_demand_i);
		pulse(pwr_btn_i);
		chk(pwr_en_o, 1'b0);
		tick(2);
		chk(acpi_state_o, bpc_pkg::BPC_SLP_S5);
		chk(fan_pwm_o, 8'h00);
	endtask

	task automatic t_wdt;
		turn_on;
		wdt_action_i = bpc_pkg::BPC_WDT_OFF;
		pulse(wdt_expire_i);
		chk(pwr_en_o, 1'b0);
		turn_on;
		wdt_action_i = bpc_pkg::BPC_WDT_CYCLE;
		pulse(wdt_expire_i);
		tick(8);
		chk(pwr_en_o, 1'b0);
		wait_led(1'b1);
	endtask

	task automatic t_cmd;
		pulse(cmd_off_i);
		chk(pwr_en_o, 1'b0);
		tick(3);
		cmd_off_i = 1'b1;
		pulse(cmd_on_i);
		cmd_off_i = 1'b0;
		chk(pwr_en_o, 1'b0);
		turn_on;
		pulse(cmd_cycle_i);
		chk(pwr_en_o, 1'b0);
		wait_led(1'b1);
		cmd_off_i = 1'b1;
		pulse(cmd_cycle_i);
		cmd_off_i = 1'b0;
		tick(30);
		chk(pwr_en_o, 1'b0);
	endtask

	task automatic t_auto;
		retain_en_i = 1'b0;
		pulse(ac_restored_i);
		chk(pwr_en_o, 1'b0);
		tick(1);
		retain_en_i = 1'b1;
		pulse(ac_restored_i);
		chk(pwr_en_o, 1'b1);
		wait_led(1'b1);
		pulse(cmd_off_i);
		tick(3);
		pulse(wol_i);
		wait_led(1'b1);
	endtask

	task automatic t_sleep;
		int c;
		for (c = 1; c < 5; c++) begin
			chipset_hub_slp_i = 3'(c);
			pulse(chipset_hub_slp_vld_i);
			chk(sleep_reject_o, 1'b1);
			beeps(bpc_pkg::BPC_BEEPS_SLEEP);
		end
		chk(status_led_o, 1'b1);
		chipset_hub_slp_i = bpc_pkg::BPC_SLP_S5;
		pulse(chipset_hub_slp_vld_i);
		tick(2);
		chk(pwr_en_o, 1'b0);
		chk(acpi_state_o, bpc_pkg::BPC_SLP_S5);
		chipset_hub_slp_i = bpc_pkg::BPC_SLP_S0;
		pulse(chipset_hub_slp_vld_i);
		chk(pwr_en_o, 1'b1);
		wait_led(1'b1);
	endtask

	task automatic t_fault;
		drop = 1'b1;
		tick(3);
		chk(pwr_en_o, 1'b0);
		drop = 1'b0;
		beeps(bpc_pkg::BPC_BEEPS_FAULT);
		chk(status_led_o, 1'b0);
	endtask

	task automatic t_panel;
		lockout_i = 4'hF;
		pulse(pwr_btn_i);
		chk(pwr_en_o, 1'b1);
		wait_led(1'b1);
		pulse(ident_btn_i);
		tick(1);
		chk(chassis_identify_led_o, 1'b0);
		pulse(pwr_btn_i);
		tick(2);
		chk(pwr_en_o, 1'b1);
		lockout_i = 4'h0;
		pulse(ident_btn_i);
		tick(1);
		chk(chassis_identify_led_o, 1'b1);
		pulse(ident_btn_i);
		tick(1);
		chk(chassis_identify_led_o, 1'b0);
		pulse(cmd_ident_on_i);
		tick(1);
		chk(chassis_identify_led_o, 1'b1);
		pulse(cmd_ident_off_i);
		tick(1);
		chk(chassis_identify_led_o, 1'b0);
		pulse(diag_btn_i);
		chk(btn_seen_o, 4'h4);
		chk(diag_int_o, 1'b1);
		pulse(rst_btn_i);
		chk(btn_seen_o, 4'h2);
		chk(sys_rst_o, 1'b1);
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_i);
		#1;
		chk(pwr_en_o, 1'b0);
		chk(fan_pwm_o, 8'h00);
		chk(sys_rst_o, 1'b1);
		chk(acpi_state_o, bpc_pkg::BPC_SLP_S5);
		rst_i = 1'b0;
		tick(1);
		t_button;
		t_wdt;
		t_cmd;
		t_auto;
		t_sleep;
		t_fault;
		t_panel;
		finish_test;
	end

	// a hang costs at most 8000 cycles, over ten times the planned run
	initial begin
		#(20 * 8000);
		miscompares++;
		finish_test;
	end
endmodule
